// ==== core/eit_pkg.sv ====
// package for the event interval timer: register map, field layout, modes, timing
package eit_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] LO_THR_OFF = 8'h04;
	localparam logic [7:0] HI_THR_OFF = 8'h08;
	localparam logic [7:0] BMIN_OFF = 8'h0C;
	localparam logic [7:0] BMAX_OFF = 8'h10;
	localparam logic [7:0] RESULT_OFF = 8'h14;
	localparam logic [7:0] STATUS_OFF = 8'h18;
	localparam logic [7:0] COUNT_OFF = 8'h1C;
	// ==========================================
	// control field positions
	localparam int MEAS_LSB = 0;
	localparam int OMODE_LSB = 2;
	localparam int PTEST_LSB = 4;
	localparam int STEST_LSB = 7;
	localparam int ENSEL_LSB = 10;
	localparam int BOUND_BIT = 12;
	localparam int SWEN_BIT = 13;
	localparam int TAU_LSB = 16;
	localparam int UNIT_LSB = 20;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] BMAX_RST = 32'hFFFF_FFFF;
	// ==========================================
	// timing
	localparam int MIN_SAMPLES = 2;
	localparam int CLK_HZ = 10_000_000;
	localparam logic [31:0] TICKS_PER_MS = 32'(CLK_HZ / 1000);
	localparam logic [31:0] TICKS_PER_US = 32'(CLK_HZ / 1_000_000);
	localparam logic [31:0] RATE_HZ_NUM = 32'(CLK_HZ);
	localparam logic [31:0] RATE_BPM_NUM = 32'(CLK_HZ * 60 / 1000);
	// ==========================================
	// enumerations
	typedef enum logic [1:0] {MEAS_PERIOD, MEAS_RATE, MEAS_DURATION, MEAS_DELAY} eit_meas_t;
	typedef enum logic [1:0] {OUT_LATCH, OUT_SMOOTH, OUT_LIVE, OUT_RSVD} eit_omode_t;
	typedef enum logic [2:0] {
		TST_TRUE, TST_FALSE, TST_ABOVE, TST_BELOW, TST_BETWEEN, TST_OUTSIDE
	} eit_test_t;
	typedef enum logic [1:0] {EN_NONE, EN_INPUT, EN_SW} eit_ensel_t;
	typedef enum logic {ST_IDLE, ST_RUN} eit_state_t;
endpackage : eit_pkg

// ==== core/eit_truth_test.sv ====
// truth test applied to one signed sample
`timescale 1ns/1ps
module eit_truth_test #(
	parameter int W = 32
) (
	input wire logic signed [W-1:0] sample,
	input wire logic [2:0] test_sel,
	input wire logic signed [W-1:0] lower_threshold,
	input wire logic signed [W-1:0] upper_threshold,
	output logic pass
);
	// elaboration check: a signed test needs a sign bit and a value bit
	if (W < 2) begin : g_bad_width
		$error("eit_truth_test: width too small");
	end
	// comparison selected by test code
	always_comb begin
		case (eit_pkg::eit_test_t'(test_sel))
			eit_pkg::TST_TRUE: pass = (sample > 0);
			eit_pkg::TST_FALSE: pass = (sample <= 0);
			eit_pkg::TST_ABOVE: pass = (sample > lower_threshold);
			eit_pkg::TST_BELOW: pass = (sample < lower_threshold);
			eit_pkg::TST_BETWEEN: pass = (sample >= lower_threshold) && (sample <= upper_threshold);
			eit_pkg::TST_OUTSIDE: pass = (sample < lower_threshold) || (sample > upper_threshold);
			default: pass = 1'b0;
		endcase
	end
endmodule : eit_truth_test

// ==== core/eit_timer.sv ====
// event interval timer core with apb register file
`timescale 1ns/1ps
module eit_timer #(
	parameter int W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [W-1:0] primary_in,
	input wire logic signed [W-1:0] secondary_in,
	input wire logic enable_in,
	output logic [31:0] result,
	output logic valid
);
	// elaboration check: the datapath is built for 32-bit samples
	if (W != 32) begin : g_bad_width
		$error("eit_timer: only 32-bit samples supported");
	end

	// ==========================================
	// state record
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] lo_thr;
		logic [31:0] hi_thr;
		logic [31:0] bmin;
		logic [31:0] bmax;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic prim_prev;
		logic sec_prev;
		eit_pkg::eit_state_t state;
		logic [31:0] count;
		logic [31:0] last_meas;
		logic [31:0] result;
		logic valid;
		logic [31:0] meas_count;
	} eit_state_rec_t;

	eit_state_rec_t s_q, s_d;

	// ==========================================
	// control fields
	logic [1:0] meas_f, omode_f, ensel_f;
	logic [2:0] ptest_f, stest_f;
	logic bound_f, swen_f;
	logic [3:0] tau_f;
	logic [1:0] unit_f;
	assign meas_f = s_q.ctrl[eit_pkg::MEAS_LSB +: 2];
	assign omode_f = s_q.ctrl[eit_pkg::OMODE_LSB +: 2];
	assign ptest_f = s_q.ctrl[eit_pkg::PTEST_LSB +: 3];
	assign stest_f = s_q.ctrl[eit_pkg::STEST_LSB +: 3];
	assign ensel_f = s_q.ctrl[eit_pkg::ENSEL_LSB +: 2];
	assign bound_f = s_q.ctrl[eit_pkg::BOUND_BIT];
	assign swen_f = s_q.ctrl[eit_pkg::SWEN_BIT];
	assign tau_f = s_q.ctrl[eit_pkg::TAU_LSB +: 4];
	assign unit_f = s_q.ctrl[eit_pkg::UNIT_LSB +: 2];

	// ==========================================
	// truth tests on both inputs
	logic prim_pass, sec_pass;
	eit_truth_test #(.W(W)) u_prim (
		.sample(primary_in),
		.test_sel(ptest_f),
		.lower_threshold(s_q.lo_thr),
		.upper_threshold(s_q.hi_thr),
		.pass(prim_pass)
	);
	eit_truth_test #(.W(W)) u_sec (
		.sample(secondary_in),
		.test_sel(stest_f),
		.lower_threshold(s_q.lo_thr),
		.upper_threshold(s_q.hi_thr),
		.pass(sec_pass)
	);

	// ==========================================
	// unit conversion helpers
	function automatic logic [31:0] to_time(input logic [31:0] ticks, input logic [1:0] u);
		case (u)
			2'd0: to_time = ticks / eit_pkg::RATE_HZ_NUM;
			2'd1: to_time = ticks / eit_pkg::TICKS_PER_MS;
			2'd2: to_time = ticks / eit_pkg::TICKS_PER_US;
			default: to_time = ticks;
		endcase
	endfunction : to_time

	function automatic logic [31:0] to_rate(input logic [31:0] ticks, input logic [1:0] u);
		logic [31:0] t;
		t = (ticks == 32'h0000_0000) ? 32'h0000_0001 : ticks;
		case (u)
			2'd0: to_rate = eit_pkg::RATE_HZ_NUM / t;
			2'd1: to_rate = eit_pkg::TICKS_PER_MS / t;
			default: to_rate = eit_pkg::RATE_BPM_NUM * 32'd1000 / t;
		endcase
	endfunction : to_rate

	// ==========================================
	// combinational decode
	logic run, prim_on, prim_off, sec_on, meas_ok, take;
	logic [31:0] elapsed, conv, clamped, output_mode_a, live_val, elapsed_unit;
	logic signed [33:0] diff;
	eit_pkg::eit_meas_t mode;

	always_comb begin
		mode = eit_pkg::eit_meas_t'(meas_f);
		case (eit_pkg::eit_ensel_t'(ensel_f))
			eit_pkg::EN_NONE: run = 1'b1;
			eit_pkg::EN_INPUT: run = enable_in;
			eit_pkg::EN_SW: run = swen_f;
			default: run = 1'b1;
		endcase
		prim_on = run && prim_pass && !s_q.prim_prev;
		prim_off = run && !prim_pass && s_q.prim_prev;
		sec_on = run && (mode == eit_pkg::MEAS_DELAY) && sec_pass && !s_q.sec_prev;
		elapsed = s_q.count + 32'd1;
		elapsed_unit = to_time(elapsed, unit_f);
		conv = (mode == eit_pkg::MEAS_RATE) ? to_rate(elapsed, unit_f) : elapsed_unit;
		clamped = conv;
		if (bound_f && conv < s_q.bmin) begin
			clamped = s_q.bmin;
		end else if (bound_f && conv > s_q.bmax) begin
			clamped = s_q.bmax;
		end
		// measurement completion by mode
		take = 1'b0;
		meas_ok = 1'b1;
		if (elapsed < 32'(eit_pkg::MIN_SAMPLES)) begin
			meas_ok = 1'b0;
		end
		case (mode)
			eit_pkg::MEAS_PERIOD: take = (s_q.state == eit_pkg::ST_RUN) && prim_on;
			eit_pkg::MEAS_RATE: take = (s_q.state == eit_pkg::ST_RUN) && prim_on;
			eit_pkg::MEAS_DURATION: begin
				take = (s_q.state == eit_pkg::ST_RUN) && prim_off;
				if (bound_f && (conv < s_q.bmin || conv > s_q.bmax)) begin
					meas_ok = 1'b0;
				end
			end
			default: begin
				take = (s_q.state == eit_pkg::ST_RUN) && sec_on;
				if (bound_f && (conv < s_q.bmin || conv > s_q.bmax)) begin
					meas_ok = 1'b0;
				end
			end
		endcase
		take = take && meas_ok;
		diff = $signed({2'b00, clamped}) - $signed({2'b00, s_q.result});
		output_mode_a = 32'(s_q.result + 32'(diff >>> tau_f));
		// live ramp from zero or minimum
		live_val = elapsed_unit;
		// minimum floor only for period; duration and delay ramp from zero
		if (bound_f && mode == eit_pkg::MEAS_PERIOD && live_val < s_q.bmin) begin
			live_val = s_q.bmin;
		end
		if (bound_f && live_val > s_q.bmax) begin
			live_val = s_q.bmax;
		end
	end

	// ==========================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.valid = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		// apb: answer in the access cycle after setup
		if (psel && !penable) begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0000_0000;
			if (paddr == eit_pkg::CTRL_OFF) begin
				s_d.prdata = s_q.ctrl;
			end else if (paddr == eit_pkg::LO_THR_OFF) begin
				s_d.prdata = s_q.lo_thr;
			end else if (paddr == eit_pkg::HI_THR_OFF) begin
				s_d.prdata = s_q.hi_thr;
			end else if (paddr == eit_pkg::BMIN_OFF) begin
				s_d.prdata = s_q.bmin;
			end else if (paddr == eit_pkg::BMAX_OFF) begin
				s_d.prdata = s_q.bmax;
			end else if (paddr == eit_pkg::RESULT_OFF) begin
				s_d.prdata = s_q.result;
			end else if (paddr == eit_pkg::STATUS_OFF) begin
				s_d.prdata = {29'h0, run, s_q.state == eit_pkg::ST_RUN, s_q.prim_prev};
			end else if (paddr == eit_pkg::COUNT_OFF) begin
				s_d.prdata = s_q.meas_count;
			end else begin
				s_d.pslverr = 1'b1;
			end
		end
		// write takes effect at the completing edge
		if (psel && penable && pwrite && s_q.pready) begin
			if (paddr == eit_pkg::CTRL_OFF) begin
				s_d.ctrl = pwdata;
			end else if (paddr == eit_pkg::LO_THR_OFF) begin
				s_d.lo_thr = pwdata;
			end else if (paddr == eit_pkg::HI_THR_OFF) begin
				s_d.hi_thr = pwdata;
			end else if (paddr == eit_pkg::BMIN_OFF) begin
				s_d.bmin = pwdata;
			end else if (paddr == eit_pkg::BMAX_OFF) begin
				s_d.bmax = pwdata;
			end
		end
		if (!run) begin
			s_d.state = eit_pkg::ST_IDLE;
			s_d.count = 32'h0000_0000;
			s_d.prim_prev = 1'b1;
			s_d.sec_prev = 1'b1;
		end else begin
			s_d.prim_prev = prim_pass;
			s_d.sec_prev = sec_pass;
			if (s_q.state == eit_pkg::ST_RUN) begin
				s_d.count = elapsed;
			end
			if (take) begin
				s_d.valid = 1'b1;
				s_d.last_meas = clamped;
				s_d.meas_count = s_q.meas_count + 32'd1;
				s_d.result = clamped;
				if (omode_f == eit_pkg::OUT_SMOOTH) begin
					s_d.result = output_mode_a;
				end
			end
			if (omode_f == eit_pkg::OUT_LIVE && s_q.state == eit_pkg::ST_RUN) begin
				case (mode)
					eit_pkg::MEAS_RATE: begin
						if (!take && to_rate(elapsed, unit_f) < s_q.result) begin
							s_d.result = (bound_f && conv < s_q.bmin) ? s_q.bmin : conv;
						end
					end
					eit_pkg::MEAS_DURATION: begin
						if (!prim_off) begin
							s_d.result = live_val;
						end
					end
					eit_pkg::MEAS_DELAY: begin
						if (!take) begin
							s_d.result = live_val;
						end
					end
					default: begin
						if (!take) begin
							s_d.result = live_val;
						end
					end
				endcase
			end
			// start or restart of an interval
			if (mode == eit_pkg::MEAS_DURATION) begin
				if (prim_on) begin
					s_d.state = eit_pkg::ST_RUN;
					s_d.count = 32'h0000_0000;
				end else if (prim_off || (s_q.state == eit_pkg::ST_RUN
					&& bound_f && conv > s_q.bmax)) begin
					s_d.state = eit_pkg::ST_IDLE;
				end
			end else if (mode == eit_pkg::MEAS_DELAY) begin
				if (prim_on && !(bound_f && s_q.state == eit_pkg::ST_RUN && conv < s_q.bmin)) begin
					s_d.state = eit_pkg::ST_RUN;
					s_d.count = 32'h0000_0000;
				end else if (take) begin
					s_d.state = eit_pkg::ST_IDLE;
				end
			end else if (prim_on) begin
				s_d.state = eit_pkg::ST_RUN;
				s_d.count = 32'h0000_0000;
			end
			// live reset value at the onset
			if (omode_f == eit_pkg::OUT_LIVE && prim_on && mode != eit_pkg::MEAS_RATE
				&& !take) begin
				s_d.result = bound_f && (mode == eit_pkg::MEAS_PERIOD) ? s_q.bmin : 32'h0000_0000;
			end
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl <= eit_pkg::CTRL_RST;
			s_q.bmax <= eit_pkg::BMAX_RST;
			s_q.prim_prev <= 1'b1;
			s_q.sec_prev <= 1'b1;
			s_q.state <= eit_pkg::ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign result = s_q.result;
	assign valid = s_q.valid;
endmodule : eit_timer

// ==== dv/eit_src_model.sv ====
// upstream source model: numeric pulse trains on both channels
`timescale 1ns/1ps
module eit_src_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] per,
	input wire logic [7:0] hi,
	input wire logic [7:0] dly,
	output logic signed [31:0] primary_in,
	output logic signed [31:0] secondary_in
);
	typedef struct packed {logic [7:0] cnt;} eit_src_t;
	eit_src_t q, d;
	// phase counter, one frame per pulse period
	always_comb begin
		d = q;
		d.cnt = (q.cnt >= per - 8'h01) ? 8'h00 : q.cnt + 8'h01;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) q <= '0;
		else q <= d;
	end
	// active level inside the window; idle level negative and moving every sample
	assign primary_in = q.cnt < hi ? 32'h0000_0064 : ~{24'h00_0000, q.cnt};
	assign secondary_in = q.cnt >= dly && q.cnt < dly + hi ? 32'h0000_0064 : ~{24'h00_0000, q.cnt};
endmodule : eit_src_model

// ==== dv/eit_timer_monitor.sv ====
// port checker for the event interval timer
`timescale 1ns/1ps
module eit_timer_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic enable_in,
	input wire logic [31:0] result,
	input wire logic valid
);
	typedef struct packed {logic [31:0] ctl; logic [31:0] lo; logic [31:0] hi; logic wr;} eit_mon_t;
	eit_mon_t q, d;
	logic latch, gated;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow of configuration writes
	always_comb begin
		d = q;
		d.wr = psel && penable && pready && pwrite;
		if (d.wr && paddr == eit_pkg::CTRL_OFF) d.ctl = pwdata;
		if (d.wr && paddr == eit_pkg::BMIN_OFF) d.lo = pwdata;
		if (d.wr && paddr == eit_pkg::BMAX_OFF) d.hi = pwdata;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) q <= {eit_pkg::CTRL_RST, 32'h0, eit_pkg::BMAX_RST, 1'b0};
		else q <= d;
	end
	// decoded configuration; the latch decode masked for one cycle after a write
	assign latch = !q.wr && q.ctl[3:2] == eit_pkg::OUT_LATCH;
	assign gated = q.ctl[11:10] == eit_pkg::EN_INPUT && !enable_in;
	sequence s_setup; psel && !penable; endsequence
	sequence s_done; psel && penable && pready; endsequence
	property p_answer; s_setup |=> s_done; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_gap; valid |=> !valid; endproperty
	property p_min; valid && latch && q.ctl[21:20] == 2'h3 |-> result >= 32'h2; endproperty
	property p_hold; !valid && latch |-> $stable(result); endproperty
	property p_gate; gated [*2] |=> !valid; endproperty
	property p_bound; valid && latch && q.ctl[12] |-> result >= q.lo && result <= q.hi; endproperty
	a_answer: assert property (p_answer) else $error("no ready after setup");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	a_err: assert property (p_err) else $error("error without ready");
	a_gap: assert property (p_gap) else $error("valid on two samples running");
	a_min: assert property (p_min) else $error("result under two samples");
	a_hold: assert property (p_hold) else $error("latched result moved");
	a_gate: assert property (p_gate) else $error("valid while disabled");
	a_bound: assert property (p_bound) else $error("result outside bounds");
endmodule : eit_timer_monitor
bind eit_timer eit_timer_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .enable_in, .result, .valid);

// ==== dv/event_interval_timer_tb.sv ====
// self-checking bench for the event interval timer
`timescale 1ns/1ps
module event_interval_timer_tb;
	logic pclk, presetn, psel, penable, pwrite, enable_in, pready, pslverr, valid;
	logic [7:0] paddr, per, hi, dly;
	logic [31:0] pwdata, prdata, result, rd, r;
	logic signed [31:0] primary_in, secondary_in;
	int err_total, total_checks, seed, p, k;
	eit_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .primary_in, .secondary_in, .enable_in, .result, .valid);
	eit_src_model SRC (.pclk, .presetn, .per, .hi, .dly, .primary_in, .secondary_in);
	// clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, error flag checked against the map
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		logic rdy, er;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		// answer sampled mid-cycle, taken at the following rising edge
		do begin
			@(negedge pclk);
			rdy = pready;
			er = pslverr;
			rd = prdata;
			@(posedge pclk);
			k++;
		end while (rdy !== 1'b1 && k < 9);
		chk(32'(k), 32'h0000_0001);
		chk({31'h0, er}, 32'(a > eit_pkg::COUNT_OFF));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// control word: measurement, output mode, primary test, unit
	function automatic logic [31:0] mk(input int m, input int o, input int t, input int u);
		return 32'(m) | 32'(o) << 2 | 32'(t) << 4 | 32'(u) << 20;
	endfunction : mk
	// one smoothing step with a time constant of one
	function automatic logic [31:0] smo(input logic [31:0] o, input logic [31:0] n);
		return o + 32'($signed(n - o) >>> 1);
	endfunction : smo
	task cf(input logic [31:0] c);
		apb(1'b1, eit_pkg::CTRL_OFF, c);
	endtask : cf
	// wait for n valid pulses, keep the result
	task wv(input int n);
		int c;
		c = 0;
		k = 0;
		// outputs looked at mid-cycle, where they have settled
		while (k < n && c < 999) begin
			@(negedge pclk);
			c++;
			if (valid === 1'b1) k++;
		end
		r = result;
		@(posedge pclk);
		chk(32'(k), 32'(n));
	endtask : wv
	// no valid pulse may come; two samples let an old-mode measurement drain
	task quiet();
		k = 0;
		repeat (2) @(posedge pclk);
		repeat (99) begin
			@(negedge pclk);
			if (valid !== 1'b0) k++;
		end
		@(posedge pclk);
		chk(32'(k), 32'h0);
	endtask : quiet
	task end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		#4000000;
		err_total++;
		end_of_test();
	end
	initial begin
		seed = 11026;
		err_total = 0;
		total_checks = 0;
		{presetn, psel, penable, pwrite, enable_in} = '0;
		{paddr, pwdata} = '0;
		{per, hi, dly} = {8'h0A, 8'h02, 8'h03};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// reset value, read-only result, unmapped address
		apb(1'b0, eit_pkg::BMAX_OFF, '0);
		chk(rd, eit_pkg::BMAX_RST);
		apb(1'b1, eit_pkg::RESULT_OFF, 32'hFFFF_FFFF);
		apb(1'b0, eit_pkg::RESULT_OFF, '0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h20, '0);
		chk(rd, 32'h0);
		apb(1'b1, eit_pkg::LO_THR_OFF, 32'h0000_0032);
		apb(1'b1, eit_pkg::HI_THR_OFF, 32'h0000_0096);
		$display("registers done");
		// each truth test on a random interval
		for (int t = 0; t < 6; t++) begin
			p = 4 + {$random(seed)} % 30;
			per <= 8'(p);
			cf(mk(0, 0, t, 3));
			wv(3);
			chk(r, 32'(p));
		end
		per <= 8'h02;
		hi <= 8'h01;
		wv(3);
		chk(r, 32'h0000_0002);
		per <= 8'(p);
		hi <= 8'h02;
		cf(mk(1, 0, 0, 0));
		wv(3);
		chk(r, eit_pkg::RATE_HZ_NUM / 32'(p));
		// other units on a forty-sample interval
		per <= 8'h28;
		cf(mk(1, 0, 0, 1));
		wv(3);
		chk(r, eit_pkg::RATE_HZ_NUM / 32'h0000_03E8 / 32'h0000_0028);
		cf(mk(1, 0, 0, 2));
		wv(3);
		chk(r, 32'h0000_003C * eit_pkg::RATE_HZ_NUM / 32'h0000_0028);
		cf(mk(0, 0, 0, 2));
		wv(3);
		chk(r, 32'h0000_0028 * 32'h000F_4240 / eit_pkg::RATE_HZ_NUM);
		p = 2 + {$random(seed)} % 8;
		per <= 8'h14;
		hi <= 8'(p);
		cf(mk(2, 0, 0, 3));
		wv(3);
		chk(r, 32'(p));
		dly <= 8'(p);
		hi <= 8'h02;
		cf(mk(3, 0, 0, 3) | 32'h0000_0100);
		wv(3);
		chk(r, 32'(p));
		$display("modes done");
		apb(1'b1, eit_pkg::BMIN_OFF, 32'h0000_000A);
		apb(1'b1, eit_pkg::BMAX_OFF, 32'h0000_0014);
		per <= 8'h1E;
		cf(mk(0, 0, 0, 3) | 32'h0000_1000);
		wv(3);
		chk(r, 32'h0000_0014);
		per <= 8'h05;
		wv(3);
		chk(r, 32'h0000_000A);
		per <= 8'h28;
		hi <= 8'h19;
		cf(mk(2, 0, 0, 3) | 32'h0000_1000);
		quiet();
		hi <= 8'h0F;
		wv(3);
		chk(r, 32'h0000_000F);
		// secondary accepted only inside the bounds
		hi <= 8'h02;
		dly <= 8'h0F;
		cf(mk(3, 0, 0, 3) | 32'h0000_1100);
		wv(3);
		chk(r, 32'h0000_000F);
		dly <= 8'h05;
		quiet();
		per <= 8'h0C;
		cf(mk(0, 0, 0, 3) | 32'h0000_0400);
		quiet();
		enable_in <= 1'b1;
		wv(3);
		chk(r, 32'h0000_000C);
		cf(mk(0, 0, 0, 3) | 32'h0000_0800);
		quiet();
		cf(mk(0, 0, 0, 3) | 32'h0000_2800);
		wv(3);
		chk(r, 32'h0000_000C);
		$display("bounds and enable done");
		per <= 8'h10;
		cf(mk(0, 0, 0, 3));
		wv(3);
		chk(r, 32'h0000_0010);
		cf(mk(0, 1, 0, 3) | 32'h0001_0000);
		wv(1);
		per <= 8'h20;
		wv(1);
		chk(r, smo(32'h0000_0010, 32'h0000_0020));
		wv(1);
		chk(r, smo(smo(32'h0000_0010, 32'h0000_0020), 32'h0000_0020));
		cf(mk(0, 2, 0, 3) | 32'h0000_1000);
		wv(2);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk(result, 32'h0000_000A);
		repeat (24) @(posedge pclk);
		@(negedge pclk);
		chk(result, 32'h0000_0014);
		@(posedge pclk);
		// live rate decays once the gap outgrows the last interval
		per <= 8'h14;
		cf(mk(1, 2, 0, 0));
		wv(2);
		chk(r, eit_pkg::RATE_HZ_NUM / 32'h0000_0014);
		per <= 8'h50;
		repeat (59) @(posedge pclk);
		@(negedge pclk);
		chk(result, eit_pkg::RATE_HZ_NUM / 32'h0000_003C);
		@(posedge pclk);
		wv(1);
		chk(r, eit_pkg::RATE_HZ_NUM / 32'h0000_0050);
		// live duration holds the offset value
		hi <= 8'h0C;
		per <= 8'h28;
		cf(mk(2, 2, 0, 3));
		wv(2);
		chk(r, 32'h0000_000C);
		repeat (10) @(posedge pclk);
		@(negedge pclk);
		chk(result, 32'h0000_000C);
		@(posedge pclk);
		// live delay holds the secondary value
		dly <= 8'h09;
		hi <= 8'h02;
		cf(mk(3, 2, 0, 3) | 32'h0000_0100);
		wv(2);
		chk(r, 32'h0000_0009);
		repeat (10) @(posedge pclk);
		@(negedge pclk);
		chk(result, 32'h0000_0009);
		@(posedge pclk);
		$display("output modes done");
		// reset in mid-run returns outputs and registers to idle values
		presetn <= 1'b0;
		@(negedge pclk);
		chk(result, 32'h0000_0000);
		chk({31'h0, valid}, 32'h0000_0000);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, eit_pkg::CTRL_OFF, '0);
		chk(rd, eit_pkg::CTRL_RST);
		$display("reset done");
		end_of_test();
	end
endmodule : event_interval_timer_tb
